// ### core/otc_pkg.sv
// Shared constants for the on-chip trigger capture unit
package otc_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] OTC_CTRL = 12'h000;
	localparam logic [11:0] OTC_STATUS = 12'h004;
	localparam logic [11:0] OTC_IRQ_STAT = 12'h008;
	localparam logic [11:0] OTC_IRQ_MASK = 12'h00C;
	localparam logic [11:0] OTC_WATCH_VAL = 12'h010;
	localparam logic [11:0] OTC_WATCH_CARE = 12'h014;
	localparam logic [11:0] OTC_BP_EN = 12'h018;
	localparam logic [11:0] OTC_CNT_LIMIT = 12'h01C;
	localparam logic [11:0] OTC_SM_SEL = 12'h020;
	localparam logic [11:0] OTC_SM_COND = 12'h024;
	localparam logic [11:0] OTC_RD_ADDR = 12'h028;
	localparam logic [11:0] OTC_RD_DATA = 12'h02C;
	localparam logic [11:0] OTC_RD_REPEAT = 12'h030;
	// ---------------------------------------------------------------
	// Fields
	// ---------------------------------------------------------------
	localparam int OTC_CTRL_ARM = 0;
	localparam int OTC_CTRL_MODE_LSB = 1;
	localparam int OTC_CTRL_COMP = 3;
	localparam int OTC_CTRL_RELEASE = 4;
	localparam int OTC_IRQ_TRIG = 0;
	localparam int OTC_IRQ_FULL = 1;
	localparam logic [31:0] OTC_RESET_WORD = 32'h0000_0000;
	localparam logic [31:0] OTC_ALL_CARE = 32'hFFFF_FFFF;
	localparam int OTC_SM_STATES = 4;
	localparam int OTC_CNT_WIDTH = 16;
	// Trigger modes
	typedef enum logic [1:0] {OTC_MODE_SIMPLE, OTC_MODE_COUNTER, OTC_MODE_SM} otc_mode_type;
	// Capture states
	typedef enum {OTC_IDLE, OTC_ARMED, OTC_DONE} otc_cap_type;
endpackage

// ### core/otc_capture_unit.sv
// One trigger and capture unit with APB register access
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module otc_capture_unit
#(
	parameter int WATCH_W = 8,
	parameter int BP_N = 4,
	parameter int DEPTH_LOG2 = 6,
	parameter int CNT_W = otc_pkg::OTC_CNT_WIDTH,
	parameter int SM_STATES = otc_pkg::OTC_SM_STATES,
	parameter bit SAMPLE_NEGEDGE = 1'b0
)
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Observed design
	input wire logic sample_clk,
	input wire logic [WATCH_W-1:0] watch_in,
	input wire logic [BP_N-1:0] bp_active,
	input wire logic group_arm,
	// Status out
	output logic irq,
	output logic triggered,
	output logic data_ready
);
	import otc_pkg::*;

	localparam int DEPTH = 1 << DEPTH_LOG2;
	localparam int CW = (CNT_W > 0) ? CNT_W : 1;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic arm_sw;
	otc_mode_type mode;
	logic comp_en;
	logic [WATCH_W-1:0] watch_val;
	logic [WATCH_W-1:0] watch_care;
	logic [BP_N-1:0] bp_en;
	logic [CW-1:0] cnt_limit;
	logic [1:0] sm_sel;
	logic [WATCH_W-1:0] sm_val [SM_STATES];
	logic [DEPTH_LOG2-1:0] rd_addr;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	otc_cap_type cap_state;
	logic [DEPTH_LOG2-1:0] wr_ptr;
	logic wrapped;
	logic [WATCH_W-1:0] mem_data [DEPTH];
	logic [15:0] mem_rep [DEPTH];
	logic [WATCH_W-1:0] last_data;
	logic [15:0] rep_cnt;
	logic [CW-1:0] ev_cnt;
	logic [1:0] sm_state;
	logic samp_d;
	logic samp_q;

	wire logic wr_acc = psel && penable && pwrite && pce;
	wire logic rd_acc = psel && penable && !pwrite && pce;

	// Match with don't-care bits; zero care bits always match
	function automatic logic masked_match(input logic [WATCH_W-1:0] v,
		input logic [WATCH_W-1:0] ref_v, input logic [WATCH_W-1:0] care);
		masked_match = ((v ^ ref_v) & care) == '0;
	endfunction

	// ---------------------------------------------------------------
	// Sample edge select: sampling runs in pclk, edge picked on sample_clk
	// ---------------------------------------------------------------
	// Edge detection on the sampled clock keeps one clock domain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			samp_d <= 1'b0;
			samp_q <= 1'b0;
		end
		else if (pce)
		begin
			samp_d <= sample_clk;
			samp_q <= samp_d;
		end
	end
	wire logic samp_edge = SAMPLE_NEGEDGE ? (samp_q && !samp_d) : (!samp_q && samp_d);

	// ---------------------------------------------------------------
	// Trigger logic
	// ---------------------------------------------------------------
	wire logic sig_match = masked_match(watch_in, watch_val, watch_care);
	wire logic bp_hit = |(bp_active & bp_en);
	wire logic simple_trig = sig_match && bp_hit;
	logic next_trig;
	// Mode select; simple mode after reset
	always_comb
	begin
		case (mode)
			OTC_MODE_SIMPLE: next_trig = simple_trig;
			OTC_MODE_COUNTER: next_trig = (CNT_W > 0) ? (simple_trig && ev_cnt == cnt_limit)
				: simple_trig;
			OTC_MODE_SM: next_trig = (sm_state == 2'(SM_STATES - 1)) && bp_hit
				&& masked_match(watch_in, sm_val[sm_state], watch_care);
			default: next_trig = simple_trig;
		endcase
	end

	// Event counter; unused and constant when width is zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev_cnt <= '0;
		else if (pce && cap_state != OTC_ARMED)
			ev_cnt <= '0;
		else if (pce && samp_edge && simple_trig && CNT_W > 0)
			ev_cnt <= ev_cnt + 1'b1;
	end

	// State sequencer walks on per-state conditions loaded by software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sm_state <= '0;
		else if (pce && cap_state != OTC_ARMED)
			sm_state <= '0;
		else if (pce && samp_edge && sm_state != 2'(SM_STATES - 1)
			&& masked_match(watch_in, sm_val[sm_state], watch_care))
			sm_state <= sm_state + 1'b1;
	end

	// ---------------------------------------------------------------
	// Capture state machine
	// ---------------------------------------------------------------
	// Group arm lets several units start on the same pclk cycle
	wire logic arm_req = arm_sw || group_arm;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cap_state <= OTC_IDLE;
		else if (pce)
		begin
			case (cap_state)
				OTC_IDLE: if (arm_req) cap_state <= OTC_ARMED;
				OTC_ARMED: if (samp_edge && next_trig) cap_state <= OTC_DONE;
				OTC_DONE: if (wr_acc && paddr == OTC_CTRL && pwdata[OTC_CTRL_RELEASE])
					cap_state <= OTC_IDLE;
				default: cap_state <= OTC_IDLE;
			endcase
		end
	end
	// Simple-mode decisions checked at the capture state
	wire logic simple_eval = pce && mode == OTC_MODE_SIMPLE && cap_state == OTC_ARMED && samp_edge;
	property p_no_match_hold;
		@(posedge pclk) disable iff (!presetn)
		simple_eval && ((watch_in ^ watch_val) & watch_care) != '0 |=> cap_state == OTC_ARMED;
	endproperty
	a_no_match_hold: assert property (p_no_match_hold)
		else $error("trigger fired without a signal match");
	property p_no_bp_hold;
		@(posedge pclk) disable iff (!presetn)
		simple_eval && (bp_active & bp_en) == '0 |=> cap_state == OTC_ARMED;
	endproperty
	a_no_bp_hold: assert property (p_no_bp_hold)
		else $error("trigger fired without an enabled breakpoint");
	property p_simple_fire;
		@(posedge pclk) disable iff (!presetn)
		simple_eval && sig_match && bp_hit |=> cap_state == OTC_DONE;
	endproperty
	a_simple_fire: assert property (p_simple_fire)
		else $error("match and breakpoint together did not fire");
	property p_group_arm;
		@(posedge pclk) disable iff (!presetn)
		pce && cap_state == OTC_IDLE && group_arm |=> cap_state == OTC_ARMED;
	endproperty
	a_group_arm: assert property (p_group_arm)
		else $error("group arm did not arm an idle unit");

	// Buffer write; run-length repeat count when compression is on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr <= '0;
			wrapped <= 1'b0;
			last_data <= '0;
			rep_cnt <= '0;
		end
		else if (pce && cap_state == OTC_IDLE && arm_req)
		begin
			wr_ptr <= '0;
			wrapped <= 1'b0;
			rep_cnt <= '0;
		end
		else if (pce && cap_state == OTC_ARMED && samp_edge)
		begin
			if (comp_en && rep_cnt != 16'hFFFF && watch_in == last_data && wr_ptr != '0)
			begin
				rep_cnt <= rep_cnt + 16'h0001;
				mem_rep[wr_ptr - 1'b1] <= rep_cnt + 16'h0001;
			end
			else
			begin
				mem_data[wr_ptr] <= watch_in;
				mem_rep[wr_ptr] <= 16'h0000;
				rep_cnt <= '0;
				wr_ptr <= wr_ptr + 1'b1;
				if (wr_ptr == DEPTH_LOG2'(DEPTH - 1))
					wrapped <= 1'b1;
			end
			last_data <= watch_in;
		end
	end
	// Captured contents stay put until released
	property p_done_frozen;
		@(posedge pclk) disable iff (!presetn)
		cap_state == OTC_DONE |=> $stable(wr_ptr) && $stable(wrapped);
	endproperty
	a_done_frozen: assert property (p_done_frozen)
		else $error("buffer pointer moved after the trigger");

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			arm_sw <= 1'b0;
			mode <= OTC_MODE_SIMPLE;
			comp_en <= 1'b0;
			watch_val <= '0;
			watch_care <= '0;
			bp_en <= '0;
			cnt_limit <= '0;
			sm_sel <= '0;
			rd_addr <= '0;
			irq_mask <= '0;
		end
		else if (pce)
		begin
			arm_sw <= 1'b0;
			if (wr_acc)
			begin
				case (paddr)
					OTC_CTRL:
					begin
						arm_sw <= pwdata[OTC_CTRL_ARM];
						mode <= otc_mode_type'(pwdata[OTC_CTRL_MODE_LSB +: 2]);
						comp_en <= pwdata[OTC_CTRL_COMP];
					end
					OTC_IRQ_MASK: irq_mask <= pwdata[1:0];
					OTC_WATCH_VAL: watch_val <= pwdata[WATCH_W-1:0];
					OTC_WATCH_CARE: watch_care <= pwdata[WATCH_W-1:0];
					OTC_BP_EN: bp_en <= pwdata[BP_N-1:0];
					OTC_CNT_LIMIT: cnt_limit <= pwdata[CW-1:0];
					OTC_SM_SEL: sm_sel <= pwdata[1:0];
					OTC_RD_ADDR: rd_addr <= pwdata[DEPTH_LOG2-1:0];
					default: ;
				endcase
			end
		end
	end

	// Per-state conditions, loadable while running
	always_ff @(posedge pclk)
	begin
		if (pce && wr_acc && paddr == OTC_SM_COND)
			sm_val[sm_sel] <= pwdata[WATCH_W-1:0];
	end

	// Sticky events; a read clears only the bits it handed out, so an event
	// landing between setup and access is not lost; set still wins
	wire logic ev_trig = pce && cap_state == OTC_ARMED && samp_edge && next_trig;
	wire logic ev_full = pce && cap_state == OTC_ARMED && samp_edge
		&& wr_ptr == DEPTH_LOG2'(DEPTH - 1);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat <= '0;
		else if (pce)
			irq_stat <= (irq_stat & ~((rd_acc && paddr == OTC_IRQ_STAT) ? prdata[1:0] : 2'b00))
				| {ev_full, ev_trig};
	end

	// Read mux and registered outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
			triggered <= 1'b0;
			data_ready <= 1'b0;
		end
		else if (pce)
		begin
			pready <= psel && !penable && !pready;
			pslverr <= 1'b0;
			prdata <= '0;
			irq <= |(irq_stat & irq_mask);
			triggered <= cap_state == OTC_DONE;
			data_ready <= cap_state == OTC_DONE;
			if (psel && !penable)
			begin
				case (paddr)
					OTC_CTRL: prdata <= {27'h0, 1'b0, comp_en, mode, 1'b0};
					OTC_STATUS: prdata <= {16'h0, wrapped, 7'(wr_ptr), 6'h0, cap_state == OTC_DONE,
						cap_state == OTC_ARMED};
					OTC_IRQ_STAT: prdata <= {30'h0, irq_stat};
					OTC_IRQ_MASK: prdata <= {30'h0, irq_mask};
					OTC_WATCH_VAL: prdata <= 32'(watch_val);
					OTC_WATCH_CARE: prdata <= 32'(watch_care);
					OTC_BP_EN: prdata <= 32'(bp_en);
					OTC_CNT_LIMIT: prdata <= 32'(cnt_limit);
					OTC_SM_SEL: prdata <= {30'h0, sm_sel};
					OTC_RD_ADDR: prdata <= 32'(rd_addr);
					OTC_RD_DATA: prdata <= 32'(mem_data[rd_addr]);
					OTC_RD_REPEAT: prdata <= {16'h0, mem_rep[rd_addr]};
					default: pslverr <= 1'b0;
				endcase
			end
		end
	end
	// Status outputs follow a fired unit one pclk cycle later
	property p_done_flags;
		@(posedge pclk) disable iff (!presetn)
		pce && cap_state == OTC_DONE |=> triggered && data_ready;
	endproperty
	a_done_flags: assert property (p_done_flags)
		else $error("fired unit did not flag its data");
endmodule

// ### verification/otc_obs_model.sv
// Model of the observed logic: sample clock, watched signals, breakpoints
`timescale 1ns/1ps
module otc_obs_model
(
	// Bench side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] watch_set,
	input wire logic [3:0] bp_set,
	// Unit side
	output logic sample_clk,
	output logic [7:0] watch_in,
	output logic [3:0] bp_active
);
	logic [1:0] div;
	// Slow sample clock; values move on its falling half only, so a
	// rising edge and its late detection both see settled data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div <= 2'h0;
			sample_clk <= 1'b0;
			watch_in <= 8'h00;
			bp_active <= 4'h0;
		end
		else
		begin
			div <= div + 2'h1;
			if (div == 2'h3)
			begin
				sample_clk <= ~sample_clk;
				if (sample_clk)
				begin
					watch_in <= watch_set;
					bp_active <= bp_set;
				end
			end
		end
	end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the trigger capture unit
`timescale 1ns/1ps
module tb_top;
	import otc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic group_arm = 1'b0;
	logic pce = 1'b1;
	logic [7:0] watch_set = 8'h00;
	logic [3:0] bp_set = 4'h0;
	logic [31:0] prdata, r, r2;
	logic pready, pslverr, sample_clk, irq, triggered, data_ready;
	logic [7:0] watch_in, seed, v, c, w;
	logic [3:0] bp_active, en, bp;
	int bad_count = 0;
	int comparisons = 0;
	// --------------------------------------------------------------
	// Clock, unit and observed logic
	// --------------------------------------------------------------
	always #20 pclk = ~pclk;
	otc_capture_unit u_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_clk(sample_clk),
		.watch_in(watch_in), .bp_active(bp_active), .group_arm(group_arm), .irq(irq),
		.triggered(triggered), .data_ready(data_ready));
	otc_obs_model u_obs (.pclk(pclk), .presetn(presetn), .watch_set(watch_set),
		.bp_set(bp_set), .sample_clk(sample_clk), .watch_in(watch_in),
		.bp_active(bp_active));
	// --------------------------------------------------------------
	// Helpers and reference model
	// --------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Every cared bit must match and one enabled breakpoint be active
	function automatic logic exp_trig(input logic [7:0] wi, input logic [3:0] b);
		return ((wi & c) == (v & c)) && ((b & en) != 4'h0);
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		chk("pslverr", pslverr, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16)
		begin
			chk("pready timeout", 32'h0, 32'h1);
			print_verdict();
		end
	endtask
	// Several sample clock periods so the trigger logic has seen the inputs
	task automatic settle();
		repeat (40) @(posedge pclk);
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial
	begin
		seed = 8'h21;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OTC_CTRL, 32'h0, r);
		chk("ctrl reset", r, OTC_RESET_WORD);
		apb(1'b0, OTC_STATUS, 32'h0, r);
		chk("status reset", r, OTC_RESET_WORD);
		apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, r);
		apb(1'b0, 12'h0FC, 32'h0, r);
		chk("unmapped", r, 32'h0);
		apb(1'b0, OTC_IRQ_MASK, 32'h0, r);
		chk("mask kept", r, 32'h0);
		seed = lfsr(seed);
		v = seed;
		seed = lfsr(seed);
		c = seed | 8'h01;
		seed = lfsr(seed);
		en = seed[3:0] | 4'h1;
		apb(1'b1, OTC_WATCH_VAL, {24'h0, v}, r);
		apb(1'b1, OTC_WATCH_CARE, {24'h0, c}, r);
		apb(1'b1, OTC_BP_EN, {28'h0, en}, r);
		apb(1'b1, OTC_IRQ_MASK, 32'h1 << OTC_IRQ_TRIG, r);
		apb(1'b1, OTC_CTRL, 32'h1 << OTC_CTRL_ARM, r);
		apb(1'b0, OTC_STATUS, 32'h0, r);
		chk("armed", r[1:0], 2'b01);
		// Mismatch, unenabled breakpoint, no breakpoint, then a full hit
		for (int k = 0; k < 4; k++)
		begin
			w = (k == 0) ? (v ^ 8'h01) : (v ^ ~c);
			bp = (k == 0) ? en : (k == 1) ? ~en : (k == 2) ? 4'h0 : (en & -en);
			watch_set <= w;
			bp_set <= bp;
			settle();
			chk("triggered", triggered, exp_trig(w, bp));
		end
		chk("data_ready", data_ready, 1'b1);
		chk("irq", irq, 1'b1);
		apb(1'b0, OTC_STATUS, 32'h0, r2);
		chk("done", r2[1:0], 2'b10);
		apb(1'b0, OTC_IRQ_STAT, 32'h0, r);
		chk("irq stat", r[OTC_IRQ_TRIG], 1'b1);
		apb(1'b0, OTC_IRQ_STAT, 32'h0, r);
		chk("irq cleared", r[OTC_IRQ_TRIG], 1'b0);
		repeat (2) @(posedge pclk);
		chk("irq low", irq, 1'b0);
		// Buffer pointer must hold while the captured data waits
		watch_set <= ~w;
		settle();
		apb(1'b0, OTC_STATUS, 32'h0, r);
		chk("frozen", r, r2);
		apb(1'b1, OTC_CTRL, 32'h1 << OTC_CTRL_RELEASE, r);
		apb(1'b0, OTC_STATUS, 32'h0, r);
		chk("released", r[1:0], 2'b00);
		chk("trig clear", triggered, 1'b0);
		@(posedge pclk);
		group_arm <= 1'b1;
		@(posedge pclk);
		group_arm <= 1'b0;
		apb(1'b0, OTC_STATUS, 32'h0, r);
		chk("group armed", r[1:0], 2'b01);
		watch_set <= w;
		bp_set <= en;
		settle();
		chk("retrigger", triggered, exp_trig(w, en));
		// Newest entry holds the sample that fired
		apb(1'b0, OTC_STATUS, 32'h0, r);
		apb(1'b1, OTC_RD_ADDR, 32'(r[14:8] - 7'h01), r);
		apb(1'b0, OTC_RD_DATA, 32'h0, r);
		chk("last sample", r, {24'h0, w});
		apb(1'b0, OTC_RD_REPEAT, 32'h0, r);
		chk("no repeats", r, 32'h0);
		// Steady input with compression keeps one entry; low enable freezes
		bp_set <= 4'h0;
		settle();
		apb(1'b1, OTC_CTRL, 32'h1 << OTC_CTRL_RELEASE, r);
		apb(1'b1, OTC_CTRL, (32'h1 << OTC_CTRL_ARM) | (32'h1 << OTC_CTRL_COMP), r);
		settle();
		apb(1'b0, OTC_STATUS, 32'h0, r);
		chk("one entry", r[14:8], 7'h01);
		pce <= 1'b0;
		bp_set <= en;
		settle();
		chk("enable low", triggered, 1'b0);
		pce <= 1'b1;
		settle();
		chk("comp trig", triggered, 1'b1);
		apb(1'b1, OTC_RD_ADDR, 32'h0, r);
		apb(1'b0, OTC_STATUS, 32'h0, r2);
		chk("still one", r2[14:8], 7'h01);
		apb(1'b0, OTC_RD_REPEAT, 32'h0, r);
		chk("repeats", r[15:0] != 16'h0000, 1'b1);
		// Counter mode lets the limit's worth of hits pass first
		bp_set <= 4'h0;
		settle();
		apb(1'b1, OTC_CTRL, 32'h1 << OTC_CTRL_RELEASE, r);
		apb(1'b1, OTC_CNT_LIMIT, 32'h8, r);
		apb(1'b1, OTC_CTRL, (32'h1 << OTC_CTRL_ARM)
			| (32'(OTC_MODE_COUNTER) << OTC_CTRL_MODE_LSB), r);
		bp_set <= en;
		settle();
		chk("count wait", triggered, 1'b0);
		repeat (2) settle();
		chk("count fire", triggered, 1'b1);
		// Sequencer stalls in its last state until that condition is reloaded
		apb(1'b1, OTC_CTRL, 32'h1 << OTC_CTRL_RELEASE, r);
		for (int k = 0; k < OTC_SM_STATES; k++)
		begin
			apb(1'b1, OTC_SM_SEL, k, r);
			apb(1'b1, OTC_SM_COND, 32'((k == OTC_SM_STATES - 1) ? (v ^ c) : v), r);
		end
		apb(1'b1, OTC_CTRL, (32'h1 << OTC_CTRL_ARM)
			| (32'(OTC_MODE_SM) << OTC_CTRL_MODE_LSB), r);
		settle();
		chk("seq wait", triggered, 1'b0);
		apb(1'b1, OTC_SM_COND, {24'h0, v}, r);
		settle();
		chk("seq fire", triggered, 1'b1);
		print_verdict();
	end
endmodule
